// File: hw/cfg_store.sv
`timescale 1ns/1ps
`include "vfd_cmd_map.svh"

// Four configuration bytes; every word is a flop so readers see registered data
module cfg_store (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic wrEn,
   input wire logic [1:0] wrAddr,
   input wire logic [7:0] wrData,
   output vfd_cmd_pkg::cfg_bytes_t words
);
   import vfd_cmd_pkg::*;

   // Single write port, one byte per cycle
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         words <= {4{`CFG_RESET}};
      end else if (wrEn) begin
         words[wrAddr] <= wrData;
      end
   end

endmodule // cfg_store

// File: hw/vfd_cmd_map.svh
// Operation
// (RULE_01) Index byte low bits pick first slot
// (RULE_02) Sine setup writes four bytes from zero
// (RULE_03) Slot 0 bit 7: sine or DC
// (RULE_04) 15-bit rate word, ignored in DC
// (RULE_05) Slot 2 bit 7 adds sine offset
// (RULE_06) Soft start ramps 250 ms, else 10
// (RULE_07) Six-bit filament level sets amplitude
// (RULE_08) Slot 3 bit 6: 10 or 12 slots
// (RULE_09) Six-bit boost level sets step-up output
// (RULE_10) Sine read returns two bytes
// (RULE_11) First read byte holds four diagnostic flags
// (RULE_12) Second sine byte holds loop level
// (RULE_13) Both function straps low select DC mode
// (RULE_14) DC slot 0 bit 7 picks bridge
// (RULE_15) DC slot 0 bit 6 enables slow decay
// (RULE_16) Chop divider codes 256, 512, 1024
// (RULE_17) Twelve-bit duty, zero off, ones maximum
// (RULE_18) Four-bit probe select drives test mux
// (RULE_19) DC setup writes three bytes from zero
// (RULE_20) DC read returns one status byte
// (RULE_21) First byte: address then direction bit
// (RULE_22) Answer own address and general call
// (RULE_23) Index advances, surplus bytes ignored
`ifndef VFD_CMD_MAP_SVH
`define VFD_CMD_MAP_SVH

// Address layout
`define ADDR_FIXED 3'h4
`define ADDR_GENERAL 7'h00
// Slot counts and read lengths per mode
`define SINE_SLOTS 3'h4
`define DC_SLOTS 3'h3
`define SINE_RD_BYTES 2'h2
`define DC_RD_BYTES 2'h1
// Datagram byte positions
`define BYTE_ADDR 2'h0
`define BYTE_INDEX 2'h1
`define BYTE_DATA 2'h2
// Field positions inside the configuration bytes
`define OUT_MODE_BIT 7
`define OFFSET_BIT 7
`define SOFT_BIT 6
`define DUTY_LIM_BIT 6
`define DIR_BIT 7
`define DECAY_BIT 6
// Step-up on-time limits in sixteenths
`define DUTY_LIM_LOW 4'hA
`define DUTY_LIM_HIGH 4'hC
// Chopper divider codes
`define CHOP_DIV256 2'h0
`define CHOP_DIV512 2'h1
// Reset value of every configuration byte
`define CFG_RESET 8'h00
// Ramp times and clock rate
`define SOFT_RAMP_MS 250
`define FAST_RAMP_MS 10
`define SYS_CLK_MHZ 200
`define RAMP_STEPS 64
// Cycles the pin filter needs before straps are trusted
`define STRAP_SETTLE 3'h4

`endif

// File: hw/vfd_cmd_pkg.sv
package vfd_cmd_pkg;

   // Pins sampled from outside the clock domain
   typedef struct packed {
      logic scl;
      logic sda;
      logic addrOffsetStrap;
      logic addr_strap_rate_hi;
      logic addr_strap_rate_mid;
      logic addr_strap_rate_lo;
      logic [1:0] function_strap_pins;
      logic reset_event_flag;
      logic thermal_prewarn_flag;
      logic thermal_shutdown_flag;
      logic shortFlag;
   } pins_t;

   // Sine-mode view of the configuration bytes
   typedef struct packed {
      logic dcOutput;
      logic [14:0] rateWord;
      logic offsetEnable;
      logic softStart;
      logic [5:0] filament_level_code;
      logic boost_duty_limit;
      logic [5:0] boost_level_code;
   } sine_cfg_t;

   // DC-mode view of the configuration bytes
   typedef struct packed {
      logic direction;
      logic slow_decay_enable;
      logic [1:0] chop_divider_select;
      logic [11:0] duty;
      logic [3:0] probeSel;
   } dc_cfg_t;

   typedef logic [3:0][7:0] cfg_bytes_t;

   // Serial slave states
   typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_DONE, ST_ACK, ST_TX, ST_TX_ACK, ST_TX_LOAD} link_state_t;

endpackage

// File: hw/vfd_serial_command_decoder.sv
`timescale 1ns/1ps
`include "vfd_cmd_map.svh"

module vfd_serial_command_decoder #(
   parameter int SOFT_RAMP_CYCLES = `SOFT_RAMP_MS * 1000 * `SYS_CLK_MHZ,
   parameter int FAST_RAMP_CYCLES = `FAST_RAMP_MS * 1000 * `SYS_CLK_MHZ
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire vfd_cmd_pkg::pins_t pinsIn,
   input wire logic [7:0] loopLevel,
   input wire logic [15:0] probeSignals,
   output logic sdaOut,
   output logic sdaOe,
   output vfd_cmd_pkg::sine_cfg_t sineCfg,
   output vfd_cmd_pkg::dc_cfg_t dcCfg,
   output logic dcMode,
   output logic [5:0] sinePhase,
   output logic [5:0] filamentRampLevel,
   output logic [3:0] boostMaxOnSlots,
   output logic chopTick,
   output logic bridge1Enable,
   output logic bridge2Enable,
   output logic dcOutputOff,
   output logic probeOut
);
   import vfd_cmd_pkg::*;

   // Cycles between ramp steps for each ramp length
   localparam int SOFT_STEP = SOFT_RAMP_CYCLES / `RAMP_STEPS;
   localparam int FAST_STEP = FAST_RAMP_CYCLES / `RAMP_STEPS;

   // Highest slot number plus one that the active mode accepts
   function automatic logic [2:0] slotLimit(input logic isDc);
      slotLimit = isDc ? `DC_SLOTS : `SINE_SLOTS;
   endfunction

   // Bytes returned by a read in the active mode
   function automatic logic [1:0] readLength(input logic isDc);
      readLength = isDc ? `DC_RD_BYTES : `SINE_RD_BYTES;
   endfunction

   logic [1:0] rstSync; // Reset release synchroniser
   logic rstn; // Internal reset, released on the clock
   pins_t pinS1, pinS2, pinS3; // Three-stage pin sampler
   pins_t filt; // High once stages two and three are both high, low once they differ
   pins_t next_filt;
   logic sclPrev, sdaPrev; // Previous filtered bus levels
   logic [2:0] settle; // Wait for filter before latching straps; filter output is valid from the fourth edge
   logic strapDone; // Straps captured
   logic [6:0] ownAddr; // Own slave address
   link_state_t state;
   logic [2:0] bitCnt; // Bit position within a byte
   logic [7:0] shiftReg; // Receive shifter
   logic [7:0] txShift; // Transmit shifter
   logic [1:0] byteNum; // Byte position in the datagram, saturates at data
   logic isRead; // Direction of current datagram
   logic [2:0] writeIdx; // Next slot to be written
   logic [1:0] txIdx; // Read byte being sent
   cfg_bytes_t cfgWords; // Stored configuration
   logic [20:0] phaseAcc; // Sine phase accumulator
   logic [31:0] rampCnt; // Cycles since last ramp step
   logic [9:0] chopCnt; // Free-running chopper prescaler

   // Reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rstSync <= 2'h0;
      end else begin
         rstSync <= {rstSync[0], 1'b1};
      end
   end
   assign rstn = rstSync[1];

   // Pin sampler; the first stage only feeds the second
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         pinS1 <= '0;
         pinS2 <= '0;
         pinS3 <= '0;
         filt <= '0;
      end else begin
         pinS1 <= pinsIn;
         pinS2 <= pinS1;
         pinS3 <= pinS2;
         filt <= next_filt;
      end
   end
   // A bit rises only when stages two and three are both high and falls as soon as they differ
   assign next_filt = (pinS2 & pinS3) | (filt & ~(pinS2 ^ pinS3));

   // Bus edge and frame condition decode
   wire sclRise = filt.scl & ~sclPrev;
   wire sclFall = ~filt.scl & sclPrev;
   wire startEv = ~filt.sda & sdaPrev & filt.scl & sclPrev;
   wire stopEv = filt.sda & ~sdaPrev & filt.scl & sclPrev;
   wire [6:0] rxAddr = shiftReg[7:1];
   wire addrHit = (rxAddr == ownAddr) || (rxAddr == `ADDR_GENERAL); // see RULE_22
   wire rxIsRead = shiftReg[0]; // see RULE_21
   wire slotOk = writeIdx < slotLimit(dcMode); // see RULE_23
   wire byteDone = (state == ST_RX_DONE) & sclFall;
   wire cfgWrEn = byteDone & (byteNum == `BYTE_DATA) & slotOk;
   wire [7:0] sineStatus = {4'h0, filt.reset_event_flag, filt.thermal_prewarn_flag,
                            filt.thermal_shutdown_flag, filt.shortFlag}; // see RULE_11
   wire [7:0] dcStatus = {3'h0, dcMode, filt.reset_event_flag, filt.thermal_prewarn_flag,
                          filt.thermal_shutdown_flag, filt.shortFlag}; // see RULE_20
   wire [7:0] txFirst = dcMode ? dcStatus : sineStatus;
   wire [7:0] txNext = loopLevel; // see RULE_12
   wire txMore = ((txIdx + 2'h1) < readLength(dcMode)); // see RULE_10

   // Edge history and strap capture after the filter has settled
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sclPrev <= 1'b1;
         sdaPrev <= 1'b1;
         settle <= 3'h0;
         strapDone <= 1'b0;
         ownAddr <= 7'h00;
         dcMode <= 1'b0;
      end else begin
         sclPrev <= filt.scl;
         sdaPrev <= filt.sda;
         if (settle != `STRAP_SETTLE) begin
            settle <= settle + 3'h1;
         end else if (!strapDone) begin
            // Straps are static, caught once
            strapDone <= 1'b1;
            ownAddr <= {`ADDR_FIXED, filt.addrOffsetStrap, filt.addr_strap_rate_hi,
                        filt.addr_strap_rate_mid, filt.addr_strap_rate_lo};
            dcMode <= (filt.function_strap_pins == 2'h0); // see RULE_13
         end
      end
   end

   // Serial slave: receive, acknowledge, transmit
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         bitCnt <= 3'h0;
         shiftReg <= 8'h00;
         txShift <= 8'h00;
         byteNum <= `BYTE_ADDR;
         isRead <= 1'b0;
         writeIdx <= 3'h0;
         txIdx <= 2'h0;
         sdaOe <= 1'b0;
      end else if (stopEv || !strapDone) begin
         // Stop ends any datagram and frees the line
         state <= ST_IDLE;
         sdaOe <= 1'b0;
      end else if (startEv) begin
         // Start, or repeated start, begins a new address byte
         state <= ST_RX;
         bitCnt <= 3'h0;
         byteNum <= `BYTE_ADDR;
         sdaOe <= 1'b0;
      end else begin
         case (state)
            ST_RX: begin
               if (sclRise) begin
                  shiftReg <= {shiftReg[6:0], filt.sda};
                  bitCnt <= bitCnt + 3'h1;
                  if (bitCnt == 3'h7) begin
                     state <= ST_RX_DONE;
                  end
               end
            end
            ST_RX_DONE: begin
               if (sclFall) begin
                  state <= ST_ACK;
                  if (byteNum == `BYTE_ADDR) begin
                     // Foreign address: stay silent until next start
                     sdaOe <= addrHit;
                     isRead <= rxIsRead;
                     if (!addrHit) begin
                        state <= ST_IDLE;
                     end
                  end else if (byteNum == `BYTE_INDEX) begin
                     writeIdx <= {1'b0, shiftReg[1:0]}; // see RULE_01
                     sdaOe <= 1'b1;
                  end else begin
                     // Bytes past the last slot are refused with no acknowledge
                     sdaOe <= slotOk; // see RULE_23
                     if (slotOk) begin
                        writeIdx <= writeIdx + 3'h1; // see RULE_23
                     end
                  end
               end
            end
            ST_ACK: begin
               if (sclFall) begin
                  bitCnt <= 3'h0;
                  if (isRead) begin
                     // Release the acknowledge and present the first status bit
                     state <= ST_TX;
                     txIdx <= 2'h0;
                     txShift <= txFirst;
                     sdaOe <= ~txFirst[7];
                  end else begin
                     state <= ST_RX;
                     sdaOe <= 1'b0;
                     if (byteNum != `BYTE_DATA) begin
                        byteNum <= byteNum + 2'h1;
                     end
                  end
               end
            end
            ST_TX: begin
               if (sclFall) begin
                  bitCnt <= bitCnt + 3'h1;
                  if (bitCnt == 3'h7) begin
                     state <= ST_TX_ACK;
                     sdaOe <= 1'b0;
                  end else begin
                     txShift <= {txShift[6:0], 1'b0};
                     sdaOe <= ~txShift[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (sclRise) begin
                  // Master acknowledge with bytes left keeps the read going
                  state <= (!filt.sda && txMore) ? ST_TX_LOAD : ST_IDLE;
               end
            end
            ST_TX_LOAD: begin
               if (sclFall) begin
                  state <= ST_TX;
                  bitCnt <= 3'h0;
                  txIdx <= txIdx + 2'h1;
                  txShift <= txNext;
                  sdaOe <= ~txNext[7];
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end
   // Open drain: the pin is only ever pulled low
   assign sdaOut = 1'b0;

   // Configuration storage, written one slot per accepted byte
   cfg_store u_cfg (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .wrEn(cfgWrEn),
      .wrAddr(writeIdx[1:0]),
      .wrData(shiftReg),
      .words(cfgWords)
   );

   // Sine-mode field decode
   assign sineCfg.dcOutput = cfgWords[0][`OUT_MODE_BIT]; // see RULE_03
   assign sineCfg.rateWord = {cfgWords[0][6:0], cfgWords[1]}; // see RULE_04
   assign sineCfg.offsetEnable = cfgWords[2][`OFFSET_BIT]; // see RULE_05
   assign sineCfg.softStart = cfgWords[2][`SOFT_BIT];
   assign sineCfg.filament_level_code = cfgWords[2][5:0]; // see RULE_07
   assign sineCfg.boost_duty_limit = cfgWords[3][`DUTY_LIM_BIT];
   assign sineCfg.boost_level_code = cfgWords[3][5:0]; // see RULE_09
   // DC-mode field decode
   assign dcCfg.direction = cfgWords[0][`DIR_BIT];
   assign dcCfg.slow_decay_enable = cfgWords[0][`DECAY_BIT]; // see RULE_15
   assign dcCfg.chop_divider_select = cfgWords[0][5:4];
   assign dcCfg.duty = {cfgWords[0][3:0], cfgWords[1]}; // see RULE_17
   assign dcCfg.probeSel = cfgWords[2][3:0];

   // Cycles per step for the active ramp length
   wire [31:0] rampStep = sineCfg.softStart ? SOFT_STEP[31:0] : FAST_STEP[31:0];
   // Chopper period end for the selected divider; unused code 11 divides by 1024
   wire chopEnd = (dcCfg.chop_divider_select == `CHOP_DIV256) ? (chopCnt[7:0] == 8'hFF) :
                  (dcCfg.chop_divider_select == `CHOP_DIV512) ? (chopCnt[8:0] == 9'h1FF) :
                  (chopCnt == 10'h3FF);

   // Output generators: phase, ramp, chopper, bridges, probe
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         phaseAcc <= 21'h000000;
         rampCnt <= 32'h00000000;
         filamentRampLevel <= 6'h00;
         chopCnt <= 10'h000;
         chopTick <= 1'b0;
         boostMaxOnSlots <= `DUTY_LIM_LOW;
         bridge1Enable <= 1'b0;
         bridge2Enable <= 1'b0;
         dcOutputOff <= 1'b1;
         probeOut <= 1'b0;
      end else begin
         // Rate word has no effect while DC output is chosen
         if (!sineCfg.dcOutput) begin
            phaseAcc <= phaseAcc + {6'h00, sineCfg.rateWord}; // see RULE_04
         end
         // One level step per interval so a full ramp takes the chosen time
         if (filamentRampLevel == sineCfg.filament_level_code) begin
            rampCnt <= 32'h00000000;
         end else if (rampCnt + 32'h1 >= rampStep) begin
            rampCnt <= 32'h00000000;
            filamentRampLevel <= (filamentRampLevel < sineCfg.filament_level_code) ?
                                 filamentRampLevel + 6'h01 : filamentRampLevel - 6'h01; // see RULE_06
         end else begin
            rampCnt <= rampCnt + 32'h1;
         end
         boostMaxOnSlots <= sineCfg.boost_duty_limit ? `DUTY_LIM_HIGH : `DUTY_LIM_LOW; // see RULE_08
         chopCnt <= chopCnt + 10'h001;
         chopTick <= dcMode & chopEnd; // see RULE_16
         bridge1Enable <= dcMode & dcCfg.direction; // see RULE_14
         bridge2Enable <= dcMode & ~dcCfg.direction; // see RULE_14
         dcOutputOff <= (dcCfg.duty == 12'h000); // see RULE_17
         probeOut <= probeSignals[dcCfg.probeSel]; // see RULE_18
      end
   end
   assign sinePhase = phaseAcc[20:15];

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   a_addr_ack: assert property (byteDone && byteNum == `BYTE_ADDR && addrHit |=> sdaOe && state == ST_ACK) // see RULE_22
      else $error("own or general address not acknowledged");
   a_foreign_silent: assert property (byteDone && byteNum == `BYTE_ADDR && !addrHit |=> !sdaOe && state == ST_IDLE) // see RULE_21
      else $error("foreign address answered");
   a_index_load: assert property (byteDone && byteNum == `BYTE_INDEX |=> writeIdx == {1'b0, $past(shiftReg[1:0])}) // see RULE_01
      else $error("start index not taken from low bits");
   a_index_step: assert property (cfgWrEn |=> writeIdx == $past(writeIdx) + 3'h1 && cfgWords[$past(writeIdx[1:0])] == $past(shiftReg)) // see RULE_23
      else $error("slot not written or index not advanced");
   a_surplus_nack: assert property (byteDone && byteNum == `BYTE_DATA && writeIdx >= slotLimit(dcMode) |=> !sdaOe && $stable(cfgWords)) // see RULE_23
      else $error("byte beyond last slot accepted");
   a_read_len: assert property (state == ST_TX_LOAD |-> !dcMode && txIdx == 2'h0) // see RULE_10
      else $error("read runs past its byte count");
   a_rate_hold: assert property (sineCfg.dcOutput ##1 sineCfg.dcOutput |-> $stable(phaseAcc)) // see RULE_04
      else $error("phase moves in DC output mode");
   a_onslots: assert property ($changed(sineCfg.boost_duty_limit) |=> boostMaxOnSlots == ($past(sineCfg.boost_duty_limit) ? 4'hC : 4'hA)) // see RULE_08
      else $error("step-up on-time limit wrong");
   a_dc_strap: assert property (strapDone |=> $stable(dcMode) && dcMode == (filt.function_strap_pins == 2'h0)) // see RULE_13
      else $error("mode wrong or changed after strap capture");
   a_bridge_excl: assert property (dcMode |=> bridge1Enable == $past(dcCfg.direction) && bridge2Enable == !$past(dcCfg.direction)) // see RULE_14
      else $error("bridge enables do not follow direction");

endmodule // vfd_serial_command_decoder

// File: tb/bus_master_model.sv
`timescale 1ns/1ps

// Two-wire bus master; moves only on falling system clock edges, 16 cycles per link half period
module bus_master_model (
   input wire logic clk_sys,
   input wire logic sdaOe,
   output logic scl,
   output logic sdaLine
);
   logic pullLow; // Master pulls the data wire low

   // Open drain with pull-up: a released wire reads high, never the last value
   assign sdaLine = ~(pullLow | sdaOe);

   // Idle bus: both wires high, link clock stands still
   initial begin
      scl = 1'b1;
      pullLow = 1'b0;
   end

   // One bit slot; data moves well after the clock falls so the slave never sees it change while high
   task automatic bitSlot(input logic b, output logic seen);
      repeat (4) @(negedge clk_sys);
      pullLow = ~b;
      repeat (12) @(negedge clk_sys);
      scl = 1'b1;
      repeat (16) @(negedge clk_sys);
      seen = sdaLine;
      scl = 1'b0;
   endtask

   // Data falls while the clock is high
   task automatic startCond();
      pullLow = 1'b0;
      repeat (16) @(negedge clk_sys);
      scl = 1'b1;
      repeat (16) @(negedge clk_sys);
      pullLow = 1'b1;
      repeat (16) @(negedge clk_sys);
      scl = 1'b0;
   endtask

   // Data rises while the clock is high, then the bus idles
   task automatic stopCond();
      repeat (4) @(negedge clk_sys);
      pullLow = 1'b1;
      repeat (12) @(negedge clk_sys);
      scl = 1'b1;
      repeat (16) @(negedge clk_sys);
      pullLow = 1'b0;
      repeat (16) @(negedge clk_sys);
   endtask

   // Eight bits MSB first, then the wire is released for the slave's acknowledge
   task automatic writeByte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(d[i], s);
      end
      bitSlot(1'b1, s);
      ack = ~s;
   endtask

   // Eight bits from the slave, then our acknowledge (low) or not (high)
   task automatic readByte(input logic mAck, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bitSlot(1'b1, s);
         d[i] = s;
      end
      bitSlot(~mAck, s);
   endtask
endmodule // bus_master_model

// File: tb/test_vfd_serial_command_decoder.sv
`timescale 1ns/1ps

module test_vfd_serial_command_decoder;
   import vfd_cmd_pkg::*;

   // One write datagram: mode, start index, byte count, bytes with the first at the top
   typedef struct packed {
      logic dc;
      logic [1:0] idx;
      logic [2:0] n;
      logic [31:0] data;
   } row_t;

   localparam logic [6:0] OWN_ADDR = 7'h4A; // Fixed 100 then straps 1010
   logic clk_sys, rst_n, scl, sdaLine, sdaOut, sdaOe, dcMode, chopTick;
   logic bridge1Enable, bridge2Enable, dcOutputOff, probeOut;
   logic [9:0] pinRest; // Straps, function straps, then the four diagnostic flags
   logic [7:0] loopLevel, rdByte;
   logic [15:0] probeSignals;
   logic [5:0] sinePhase, filamentRampLevel;
   logic [3:0] boostMaxOnSlots;
   logic ack;
   pins_t pinsIn;
   sine_cfg_t sineCfg;
   dc_cfg_t dcCfg;
   logic [7:0] cfgModel [4]; // Bytes the device should hold
   logic dcNow; // Mode the straps selected at the last reset
   int n_errors = 0;
   int n_tests = 0;
   row_t rows [9] = '{
      '{1'b0, 2'h0, 3'd4, 32'h7F123FC5}, // Full sine setup
      '{1'b0, 2'h3, 3'd1, 32'h40000000}, // Single slot update
      '{1'b0, 2'h3, 3'd2, 32'h15AA0000}, // Second byte runs past the last slot
      '{1'b0, 2'h1, 3'd3, 32'h80C10000},
      '{1'b0, 2'h0, 3'd1, 32'h80000000}, // DC output type, rate ignored
      '{1'b1, 2'h0, 3'd3, 32'hA53C0F00}, // Full DC setup
      '{1'b1, 2'h0, 3'd1, 32'h50000000},
      '{1'b1, 2'h1, 3'd3, 32'h00030700}, // Duty zero, third byte dropped
      '{1'b1, 2'h0, 3'd1, 32'h30000000}  // Divider code 11
   };

   assign pinsIn = pins_t'({scl, sdaLine, pinRest});

   // System clock, 5 ns
   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end

   // Ramp counts shortened so a full ramp fits in a few hundred cycles
   vfd_serial_command_decoder #(.SOFT_RAMP_CYCLES(640), .FAST_RAMP_CYCLES(128)) DUT (
      .clk_sys(clk_sys), .rst_n(rst_n), .pinsIn(pinsIn), .loopLevel(loopLevel), .probeSignals(probeSignals),
      .sdaOut(sdaOut), .sdaOe(sdaOe), .sineCfg(sineCfg), .dcCfg(dcCfg), .dcMode(dcMode), .sinePhase(sinePhase),
      .filamentRampLevel(filamentRampLevel), .boostMaxOnSlots(boostMaxOnSlots), .chopTick(chopTick),
      .bridge1Enable(bridge1Enable), .bridge2Enable(bridge2Enable), .dcOutputOff(dcOutputOff), .probeOut(probeOut)
   );

   bus_master_model bfm (.clk_sys(clk_sys), .sdaOe(sdaOe), .scl(scl), .sdaLine(sdaLine));

   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict, reached from the main sequence or the watchdog
   task automatic results();
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Reset with the function straps set for the wanted mode; straps stay put through release
   task automatic resetDut(input logic dc);
      rst_n = 1'b0;
      dcNow = dc;
      pinRest[5:4] = dc ? 2'b00 : 2'b01;
      foreach (cfgModel[k]) cfgModel[k] = 8'h00;
      repeat (10) @(negedge clk_sys);
      chk({sdaOe, dcMode, chopTick, bridge1Enable, bridge2Enable, dcOutputOff, probeOut}, 32'h02);
      chk(32'(sineCfg) | 32'(dcCfg) | 32'(sinePhase) | 32'(filamentRampLevel), 32'h0);
      chk(boostMaxOnSlots, 4'hA);
      rst_n = 1'b1;
      repeat (20) @(negedge clk_sys);
      chk(dcMode, dc);
      $display("test reset done");
   endtask

   // Write datagram; the model keeps only bytes the device should accept
   task automatic wrCfg(input logic [7:0] addrByte, input logic [1:0] idx, input logic [2:0] n,
                        input logic [31:0] data);
      logic hit;
      logic take;
      int slot;
      hit = (addrByte[7:1] === OWN_ADDR) || (addrByte[7:1] === 7'h00);
      bfm.startCond();
      bfm.writeByte(addrByte, ack);
      chk(ack, hit);
      bfm.writeByte({6'h00, idx}, ack);
      chk(ack, hit);
      for (int i = 0; i < n; i++) begin
         slot = int'(idx) + i;
         take = hit && slot < (dcNow ? 3 : 4);
         bfm.writeByte(data[31 - 8 * i -: 8], ack);
         chk(ack, take);
         if (take) begin
            cfgModel[slot] = data[31 - 8 * i -: 8];
         end
      end
      bfm.stopCond();
   endtask

   // Decoded fields against the model bytes
   task automatic checkCfg();
      logic [5:0] p;
      int cnt;
      logic [1:0] ct;
      ct = cfgModel[0][5:4];
      if (!dcNow) begin
         chk(32'(sineCfg), {cfgModel[0], cfgModel[1], cfgModel[2], cfgModel[3][6:0]});
         chk(boostMaxOnSlots, cfgModel[3][6] ? 4'hC : 4'hA);
         // Rates used here are zero, above 0x4000 or set with DC output: two steps of a running rate always move the top bits, never a full turn
         p = sinePhase;
         repeat (2) @(negedge clk_sys);
         chk(sinePhase === p, cfgModel[0][7] || {cfgModel[0][6:0], cfgModel[1]} == 15'h0000);
      end else begin
         chk(32'(dcCfg), {cfgModel[0], cfgModel[1], cfgModel[2][3:0]});
         chk({bridge1Enable, bridge2Enable}, {cfgModel[0][7], ~cfgModel[0][7]});
         chk(dcOutputOff, {cfgModel[0][3:0], cfgModel[1]} == 12'h000);
         chk(probeOut, probeSignals[cfgModel[2][3:0]]);
         cnt = 0;
         while (chopTick !== 1'b1 && cnt < 1100) begin
            @(negedge clk_sys);
            cnt++;
         end
         cnt = 0;
         do begin
            @(negedge clk_sys);
            cnt++;
         end while (chopTick !== 1'b1 && cnt < 1100);
         chk(cnt, 32'd256 << (ct == 2'h3 ? 2 : ct));
      end
   endtask

   // Watchdog, well beyond the expected run length
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      results();
   end

   // Main sequence
   initial begin
      rst_n = 1'b0;
      pinRest = {4'hA, 2'b01, 4'h0};
      loopLevel = 8'hF3;
      probeSignals = 16'hA5C3;
      dcNow = 1'b0;
      resetDut(1'b0);
      foreach (rows[i]) begin
         if (rows[i].dc !== dcNow) begin
            resetDut(rows[i].dc);
         end
         wrCfg({OWN_ADDR, 1'b0}, rows[i].idx, rows[i].n, rows[i].data);
         checkCfg();
         $display("test row %0d done", i);
      end
      resetDut(1'b0);
      // Foreign address ignored, general call accepted
      wrCfg({7'h4B, 1'b0}, 2'h3, 3'd1, 32'h55000000);
      checkCfg();
      wrCfg(8'h00, 2'h3, 3'd1, 32'h7F000000);
      checkCfg();
      $display("test address match done");
      // Sine read: status then loop level
      pinRest[3:0] = 4'hA;
      bfm.startCond();
      bfm.writeByte({OWN_ADDR, 1'b1}, ack);
      chk(ack, 1'b1);
      bfm.readByte(1'b1, rdByte);
      chk(rdByte, {4'h0, 4'hA});
      bfm.readByte(1'b0, rdByte);
      chk(rdByte, loopLevel);
      bfm.stopCond();
      chk(sdaOe, 1'b0);
      $display("test sine read done");
      // Soft start ramps slowly, then the fast ramp falls back quickly
      wrCfg({OWN_ADDR, 1'b0}, 2'h2, 3'd1, 32'h7F000000);
      chk(filamentRampLevel != 6'h3F, 1'b1);
      repeat (700) @(negedge clk_sys);
      chk(filamentRampLevel, 6'h3F);
      wrCfg({OWN_ADDR, 1'b0}, 2'h2, 3'd1, 32'h00000000);
      repeat (150) @(negedge clk_sys);
      chk(filamentRampLevel, 6'h00);
      $display("test ramp done");
      // DC read: one status byte, then only the pull-up
      resetDut(1'b1);
      bfm.startCond();
      bfm.writeByte({OWN_ADDR, 1'b1}, ack);
      chk(ack, 1'b1);
      bfm.readByte(1'b1, rdByte);
      chk(rdByte, {4'h1, 4'hA});
      bfm.readByte(1'b0, rdByte);
      chk(rdByte, 8'hFF);
      bfm.stopCond();
      $display("test dc read done");
      results();
   end
endmodule // test_vfd_serial_command_decoder
